// File: shared/dpram_consts.svh
// timing constants for the dual-port ram port host
`ifndef DPRAM_CONSTS_SVH
`define DPRAM_CONSTS_SVH

// clock period of ref_clk
`define CLK_PERIOD_NS 4

// port timing figures, fastest grade
`define T_WC_NS   10
`define T_EW_NS   8
`define T_WP_NS   8
`define T_DW_NS   6
`define T_SWRD_NS 5
`define T_WH_NS   8
`define T_AA_NS   10
`define T_BDD_NS  10

// least times round up to whole cycles
`define CYC_MIN(ns) (((ns) + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

`define WC_CYC   `CYC_MIN(`T_WC_NS)
`define WP_CYC   `CYC_MIN(`T_WP_NS)
`define EW_CYC   `CYC_MIN(`T_EW_NS)
`define SWRD_CYC `CYC_MIN(`T_SWRD_NS)
`define WH_CYC   `CYC_MIN(`T_WH_NS)
`define AA_CYC   `CYC_MIN(`T_AA_NS)
`define BDD_CYC  `CYC_MIN(`T_BDD_NS)

// gap counters saturate at this value
`define GAP_MAX 7

`endif

// File: shared/dpram_pkg.sv
// types for the dual-port ram port host
`default_nettype none

package dpram_pkg;

  // host sequencer states
  typedef enum logic [2:0] {
    ST_IDLE,
    ST_SETUP,
    ST_WRITE,
    ST_READ,
    ST_FINISH
  } host_state_t;

endpackage : dpram_pkg

`default_nettype wire

// File: shared/tmr_if.sv
// carrier between the sequencer and its cycle timer
`default_nettype none

interface tmr_if #(
  parameter int W = 4
);
  logic         load;
  logic [W-1:0] value;
  logic         done;

  modport ctl (output load, output value, input done);
  modport tmr (input load, input value, output done);
endinterface : tmr_if

`default_nettype wire

// File: hdl/cycle_timer.sv
// down counter that times the phases of a port cycle
`default_nettype none

module cycle_timer (
  input  wire logic ref_clk,
  input  wire logic rst,
  tmr_if.tmr        t
);
  logic [$bits(t.value)-1:0] cnt_r;

  // expired once the count is spent and no reload is pending
  assign t.done = (cnt_r == '0) && !t.load;

  // load wins over counting
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      cnt_r <= '0;
    end else if (t.load) begin
      cnt_r <= t.value;
    end else if (cnt_r != '0) begin
      cnt_r <= cnt_r - 1'b1;
    end
  end
endmodule : cycle_timer

`default_nettype wire

// File: hdl/dpram_host.sv
// host that drives one port of an asynchronous dual-port ram
// Functional notes
// R1: device writes only while select and strobe low
// R2: select low is array, flag select is flags
// R3: keep array-or-flag choice stable through write
// R4: change address only with strobes inactive
// R5: late select keeps device outputs off
// R6: outputs disabled so minimum pulse width suffices
// R7: device releases data within 4 ns
// R8: space write starts by write cycle time
// R9: drive write data before end of write
// R10: hold write data past end of write
// R11: write ends at first strobe rising
// R12: flag read drives all lines alike
// R13: wait after flag write before flag read
// R14: device grants contended flag to one port
// R15: busy follows address match in master
// R16: busy follows port select in master
// R17: earlier settled port wins arbitration
// R18: colliding read valid after busy release delay
// R19: forward busy to slave before its write
// R20: hold write after busy release
// R21: port-to-port data delay bounded
// R22: read data valid after last access delay
// R23: slave suppresses writes while busy held low
// R24: master never drives both busy low
// R25: busy pins output in master, input slave
// R26: first flag writer of zero obtains token
// R27: both ports behave identically
`include "dpram_consts.svh"
`default_nettype none

module dpram_host #(
  parameter int ADDR_W = 17,
  parameter int DATA_W = 36,
  parameter int BE_W   = 4,
  parameter int TMR_W  = 4
) (
  input  wire logic              ref_clk,
  input  wire logic              rst,
  // user request side
  input  wire logic              req_valid,
  output logic                   req_ready,
  input  wire logic              req_write,
  input  wire logic              req_flag,
  input  wire logic [ADDR_W-1:0] req_addr,
  input  wire logic [DATA_W-1:0] req_wdata,
  input  wire logic [BE_W-1:0]   req_be,
  output logic                   rsp_valid,
  output logic [DATA_W-1:0]      rsp_rdata,
  // ram port pins
  output logic                   ce_n,
  output logic                   flag_space_select_n,
  output logic                   rw_n,
  output logic                   oe_n,
  output logic [BE_W-1:0]        byte_lane_enable_n,
  output logic [ADDR_W-1:0]      addr,
  output logic [DATA_W-1:0]      dq_o,
  output logic                   dq_oe,
  input  wire logic [DATA_W-1:0] dq_i,
  input  wire logic              busy_n,
  output logic                   busy_fwd_n
);

  // ***************************************************************
  // elaboration checks
  // ***************************************************************
  if (DATA_W != BE_W * 9) begin : g_bad_lanes
    $error("DATA_W must be nine bits per byte lane");
  end
  if ((1 << TMR_W) <= `AA_CYC || (1 << TMR_W) <= `BDD_CYC || (1 << TMR_W) <= `WH_CYC) begin : g_bad_tmr
    $error("TMR_W too narrow for the phase counts");
  end

  // ***************************************************************
  // state and latched request
  // ***************************************************************
  dpram_pkg::host_state_t st_r;
  dpram_pkg::host_state_t st_nxt;
  logic                   wr_q_r;
  logic                   flag_q_r;
  logic [BE_W-1:0]        be_q_r;
  logic [ADDR_W-1:0]      addr_r;
  logic [DATA_W-1:0]      dq_o_r;
  logic                   ce_n_r;
  logic                   sem_n_r;
  logic                   rw_n_r;
  logic                   oe_n_r;
  logic [BE_W-1:0]        be_n_r;
  logic                   dq_oe_r;
  logic                   rsp_valid_r;
  logic [DATA_W-1:0]      rdata_r;
  logic [2:0]             sem_gap_r;
  logic [2:0]             wr_gap_r;

  tmr_if #(.W(TMR_W)) ph ();

  cycle_timer u_phase (
    .ref_clk (ref_clk),
    .rst     (rst),
    .t       (ph)
  );

  // ***************************************************************
  // request acceptance
  // ***************************************************************
  wire flag_rd_early = req_flag && !req_write && (sem_gap_r < 3'(`SWRD_CYC));
  wire accept        = req_valid && req_ready;
  wire wr_sel        = accept ? req_write : wr_q_r;
  wire flag_sel      = accept ? req_flag : flag_q_r;
  wire [BE_W-1:0] be_sel = accept ? req_be : be_q_r;

  // a flag read waits out the write-to-read gap
  assign req_ready = (st_r == dpram_pkg::ST_IDLE) && !flag_rd_early; // R13

  // ***************************************************************
  // sequencer
  // ***************************************************************
  // phase timer reloads: pulse width, access time, busy stretch
  always_comb begin
    st_nxt   = st_r;
    ph.load  = 1'b0;
    ph.value = '0;
    case (st_r)
      dpram_pkg::ST_IDLE: begin
        if (accept) begin
          st_nxt = dpram_pkg::ST_SETUP;
        end
      end
      dpram_pkg::ST_SETUP: begin
        ph.load = 1'b1;
        if (wr_q_r) begin
          st_nxt   = dpram_pkg::ST_WRITE;
          ph.value = TMR_W'(`WP_CYC - 1);
        end else begin
          st_nxt   = dpram_pkg::ST_READ;
          ph.value = TMR_W'(`AA_CYC - 1);
        end
      end
      dpram_pkg::ST_WRITE: begin
        if (!busy_n) begin
          // busy may rise late in a cycle, so count one spare cycle
          ph.load  = 1'b1; // R20
          ph.value = TMR_W'(`WH_CYC);
        end else if (ph.done) begin
          st_nxt = dpram_pkg::ST_FINISH;
        end
      end
      dpram_pkg::ST_READ: begin
        if (!busy_n) begin
          // spare cycle covers a release just after the last low sample
          ph.load  = 1'b1; // R18
          ph.value = TMR_W'(`BDD_CYC);
        end else if (ph.done) begin
          st_nxt = dpram_pkg::ST_FINISH; // R22
        end
      end
      dpram_pkg::ST_FINISH: begin
        st_nxt = dpram_pkg::ST_IDLE;
      end
      default: begin
        st_nxt = dpram_pkg::ST_IDLE;
      end
    endcase
  end

  // ***************************************************************
  // pin decode from the next state
  // ***************************************************************
  wire sel_act    = (st_nxt == dpram_pkg::ST_WRITE) || (st_nxt == dpram_pkg::ST_READ);
  // only one of the two selects is ever low
  wire ce_n_nxt   = !(sel_act && !flag_sel); // R2
  wire sem_n_nxt  = !(sel_act && flag_sel);  // R2
  // strobe falls with the select so the device keeps its outputs off
  wire rw_n_nxt   = !(st_nxt == dpram_pkg::ST_WRITE); // R5
  // output enable stays high during writes
  wire oe_n_nxt   = !(st_nxt == dpram_pkg::ST_READ); // R6
  wire [BE_W-1:0] be_n_nxt = sel_act ? ~be_sel : {BE_W{1'b1}};
  // data driven from setup until one cycle past end of write
  wire dq_oe_nxt  = wr_sel && (st_nxt == dpram_pkg::ST_SETUP ||
                               st_nxt == dpram_pkg::ST_WRITE ||
                               st_nxt == dpram_pkg::ST_FINISH); // R9 R10
  wire rd_done    = (st_r == dpram_pkg::ST_READ) && (st_nxt == dpram_pkg::ST_FINISH);
  wire wr_done    = (st_r == dpram_pkg::ST_WRITE) && (st_nxt == dpram_pkg::ST_FINISH);
  wire wr_start   = (st_r == dpram_pkg::ST_SETUP) && wr_q_r;

  // ***************************************************************
  // registers
  // ***************************************************************
  // state and pin registers
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      st_r    <= dpram_pkg::ST_IDLE;
      ce_n_r  <= 1'b1;
      sem_n_r <= 1'b1;
      rw_n_r  <= 1'b1;
      oe_n_r  <= 1'b1;
      be_n_r  <= {BE_W{1'b1}};
      dq_oe_r <= 1'b0;
    end else begin
      st_r    <= st_nxt;
      ce_n_r  <= ce_n_nxt;
      sem_n_r <= sem_n_nxt;
      rw_n_r  <= rw_n_nxt;
      oe_n_r  <= oe_n_nxt;
      be_n_r  <= be_n_nxt;
      dq_oe_r <= dq_oe_nxt;
    end
  end

  // request capture, address moves only while idle strobes are high
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      wr_q_r   <= 1'b0;
      flag_q_r <= 1'b0;
      be_q_r   <= '0;
      addr_r   <= '0;
      dq_o_r   <= '0;
    end else if (accept) begin
      wr_q_r   <= req_write;
      flag_q_r <= req_flag; // R3
      be_q_r   <= req_be;
      addr_r   <= req_addr; // R4
      dq_o_r   <= req_wdata;
    end
  end

  // answer: one-cycle pulse at end of read or write
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      rsp_valid_r <= 1'b0;
      rdata_r     <= '0;
    end else begin
      rsp_valid_r <= rd_done || wr_done;
      if (rd_done) begin
        rdata_r <= dq_i; // R12
      end
    end
  end

  // cycles since last flag write end and since last write start
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      sem_gap_r <= 3'(`GAP_MAX);
      wr_gap_r  <= 3'(`GAP_MAX);
    end else begin
      if (wr_done && flag_q_r) begin
        sem_gap_r <= '0; // R13
      end else if (sem_gap_r != 3'(`GAP_MAX)) begin
        sem_gap_r <= sem_gap_r + 1'b1;
      end
      if (wr_start) begin
        wr_gap_r <= '0; // R8
      end else if (wr_gap_r != 3'(`GAP_MAX)) begin
        wr_gap_r <= wr_gap_r + 1'b1;
      end
    end
  end

  // ***************************************************************
  // outputs
  // ***************************************************************
  assign ce_n                = ce_n_r;
  assign flag_space_select_n = sem_n_r;
  assign rw_n                = rw_n_r;
  assign oe_n                = oe_n_r;
  assign byte_lane_enable_n  = be_n_r;
  assign addr                = addr_r;
  assign dq_o                = dq_o_r;
  assign dq_oe               = dq_oe_r;
  assign rsp_valid           = rsp_valid_r;
  assign rsp_rdata           = rdata_r;
  // master busy passes straight to a slave's busy input
  assign busy_fwd_n          = busy_n; // R19

  // ***************************************************************
  // assertions
  // ***************************************************************
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);

  sequence s_wr_pulse;
    !rw_n_r [*2];
  endsequence

  sequence s_end_hold;
    rw_n_r && dq_oe_r && $stable(dq_o_r);
  endsequence

  a_sel_excl: assert property (ce_n_r || sem_n_r) // R2
    else $error("array and flag selects low together");
  a_sel_stable: assert property ((!rw_n_r && !$past(rw_n_r)) |-> $stable({ce_n_r, sem_n_r})) // R3
    else $error("selection changed during write");
  a_addr_quiet: assert property ($changed(addr_r) |-> rw_n_r && ce_n_r && sem_n_r) // R4
    else $error("address moved with strobes active");
  a_oe_off_write: assert property (!rw_n_r |-> oe_n_r) // R6
    else $error("output enable low during write");
  a_pulse_width: assert property ($fell(rw_n_r) |-> s_wr_pulse) // R6
    else $error("write pulse shorter than minimum");
  a_data_valid: assert property ($fell(rw_n_r) |-> $past(dq_oe_r) && dq_oe_r) // R9
    else $error("write data not driven ahead of write");
  a_data_hold: assert property ($rose(rw_n_r) |-> s_end_hold) // R10
    else $error("write data not held past end of write");
  a_write_space: assert property ($fell(rw_n_r) |-> $past(wr_gap_r) >= 3'(`WC_CYC)) // R8
    else $error("write starts too close together");
  a_sem_gap: assert property (($fell(sem_n_r) && rw_n_r) |-> sem_gap_r >= 3'(`SWRD_CYC)) // R13
    else $error("flag read too soon after flag write");
  a_busy_hold: assert property (($rose(busy_n) && !rw_n_r) |-> s_wr_pulse) // R20
    else $error("write ended too soon after busy release");

endmodule : dpram_host

`default_nettype wire

// File: bench/dpram_port_model.sv
// behavioural model of one port of the dual-port ram in master wiring
`default_nettype none

module dpram_port_model (
  input  wire logic        ce_n,
  input  wire logic        flag_space_select_n,
  input  wire logic        rw_n,
  input  wire logic        oe_n,
  input  wire logic [3:0]  byte_lane_enable_n,
  input  wire logic [16:0] addr,
  input  wire logic [35:0] dq_o,
  input  wire logic        opp_sel_n,
  input  wire logic [16:0] opp_addr,
  input  wire logic        busy_fast,
  output logic [35:0]      dq_i,
  output logic             busy_n
);
  timeunit 1ns;
  timeprecision 100ps;
  // ************************************************************
  // storage, write capture and read drive
  // ************************************************************
  logic [35:0] mem [logic [16:0]];
  logic [7:0]  flag_mine;
  logic [35:0] last, wd;
  logic [16:0] wa;
  logic [3:0]  wb;
  logic        armed, wf;
  time         t_sel, t_addr, t_oe, t_busy;
  wire         arr_sel  = !ce_n && flag_space_select_n;
  wire         flag_sel = ce_n && !flag_space_select_n;
  wire         match    = !opp_sel_n && !ce_n && addr == opp_addr;

  initial begin
    flag_mine = 8'h00;
    last = 36'h0;
    dq_i = 36'h0;
    busy_n = 1'b1;
    armed = 1'b0;
    t_busy = 0;
  end
  // busy follows match on this port only, slow or prompt
  always @(match) busy_n <= #(busy_fast ? 2 : 10) !match;
  // write window is the select and strobe overlap, blocked while busy
  always @* if ((arr_sel || flag_sel) && !rw_n) begin
    wa = addr;
    wd = dq_o;
    wb = byte_lane_enable_n;
    wf = flag_sel;
    armed = busy_n;
  end
  // commit at the first strobe to rise
  always @(posedge ce_n or posedge flag_space_select_n or posedge rw_n) if (armed) begin
    armed = 1'b0;
    if (wf) flag_mine[wa[2:0]] = !wd[0];
    else begin
      if (!mem.exists(wa)) mem[wa] = 36'h0;
      for (int i = 0; i < 4; i++) if (!wb[i]) mem[wa][i*9 +: 9] = wd[i*9 +: 9];
    end
  end
  // access time stamps
  always @(ce_n, flag_space_select_n) t_sel = $time;
  always @(addr) t_addr = $time;
  always @(oe_n, byte_lane_enable_n) t_oe = $time;
  always @(posedge busy_n) t_busy = $time;
  // drive data once every access delay is met, else a changed pattern
  always #1 begin
    if (!oe_n && rw_n && (arr_sel || flag_sel) && $time >= t_sel + 10 &&
        $time >= t_addr + 10 && $time >= t_oe + 5 &&
        $time >= t_busy + 10) begin
      if (flag_sel) dq_i = {36{!flag_mine[addr[2:0]]}};
      else dq_i = mem.exists(addr) ? mem[addr] : 36'h0;
      last = dq_i;
    end else dq_i = ~last;
  end
endmodule : dpram_port_model

`default_nettype wire

// File: bench/dual_port_ram_write_sem_arbitration_tb_top.sv
// self-checking bench for the dual-port ram port host
`default_nettype none

module dual_port_ram_write_sem_arbitration_tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  logic        ref_clk = 1'b0;
  logic        rst, req_valid, req_write, req_flag, opp_sel_n, busy_fast, sel_hi_prev;
  logic        req_ready, rsp_valid, ce_n, flag_space_select_n, rw_n, oe_n, dq_oe;
  logic        busy_n, busy_fwd_n;
  logic [16:0] req_addr, opp_addr, addr, prev_addr;
  logic [35:0] req_wdata, rsp_rdata, dq_o, dq_i;
  logic [3:0]  req_be, byte_lane_enable_n;
  int          num_errors, check_count, n;

  always #2 ref_clk = ~ref_clk;

  dpram_host u_dpram_host (.ref_clk(ref_clk), .rst(rst), .req_valid(req_valid),
    .req_ready(req_ready), .req_write(req_write), .req_flag(req_flag), .req_addr(req_addr),
    .req_wdata(req_wdata), .req_be(req_be), .rsp_valid(rsp_valid), .rsp_rdata(rsp_rdata),
    .ce_n(ce_n), .flag_space_select_n(flag_space_select_n), .rw_n(rw_n), .oe_n(oe_n),
    .byte_lane_enable_n(byte_lane_enable_n), .addr(addr), .dq_o(dq_o), .dq_oe(dq_oe),
    .dq_i(dq_i), .busy_n(busy_n), .busy_fwd_n(busy_fwd_n));

  dpram_port_model u_dpram_port_model (.ce_n(ce_n), .flag_space_select_n(flag_space_select_n),
    .rw_n(rw_n), .oe_n(oe_n), .byte_lane_enable_n(byte_lane_enable_n), .addr(addr),
    .dq_o(dq_o), .opp_sel_n(opp_sel_n), .opp_addr(opp_addr), .busy_fast(busy_fast),
    .dq_i(dq_i), .busy_n(busy_n));

  // ************************************************************
  // compare, request and closing tasks
  // ************************************************************
  task automatic check_data(input logic [35:0] got, input logic [35:0] exp);
    check_count++;
    if (got !== exp) begin
      num_errors++;
      $display("MISMATCH t=%0t data %h exp %h", $time, got, exp);
    end
  endtask : check_data

  task automatic check_bit(input logic got, input logic exp);
    check_count++;
    if (got !== exp) begin
      num_errors++;
      $display("MISMATCH t=%0t pin %b exp %b", $time, got, exp);
    end
  endtask : check_bit

  task automatic check_cyc(input int got, input int lo, input int hi);
    check_count++;
    if (got < lo || got > hi) begin
      num_errors++;
      $display("MISMATCH t=%0t cycles %0d exp %0d..%0d", $time, got, lo, hi);
    end
  endtask : check_cyc

  task automatic do_req(input logic w, input logic f, input logic [16:0] a,
                        input logic [35:0] d, input logic [3:0] be, output int c);
    @(posedge ref_clk);
    req_valid <= 1'b1;
    req_write <= w;
    req_flag  <= f;
    req_addr  <= a;
    req_wdata <= d;
    req_be    <= be;
    c = 0;
    do @(negedge ref_clk); while (req_ready !== 1'b1);
    @(posedge ref_clk);
    req_valid <= 1'b0;
    do begin
      @(negedge ref_clk);
      c++;
    end while (rsp_valid !== 1'b1 && c < 60);
  endtask : do_req

  task automatic summarize;
    $display("checks %0d errors %0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : summarize

  // ************************************************************
  // scenarios
  // ************************************************************
  task automatic s_array;
    do_req(1'b1, 1'b0, 17'h00123, 36'h9a5c31e7f, 4'hf, n);
    check_cyc(n, 4, 4);
    do_req(1'b1, 1'b0, 17'h00123, 36'h000000000, 4'h5, n);
    do_req(1'b1, 1'b0, 17'h1ffff, 36'hfedcba987, 4'hf, n);
    do_req(1'b0, 1'b0, 17'h00123, 36'h0, 4'hf, n);
    check_cyc(n, 5, 5);
    check_data(rsp_rdata, 36'h9a5c31e7f & ~36'h007fc01ff);
    do_req(1'b0, 1'b0, 17'h1ffff, 36'h0, 4'hf, n);
    check_data(rsp_rdata, 36'hfedcba987);
  endtask : s_array

  task automatic s_flag;
    do_req(1'b1, 1'b1, 17'h00003, 36'h0, 4'hf, n);
    do_req(1'b0, 1'b1, 17'h00003, 36'h0, 4'hf, n);
    check_data(rsp_rdata, 36'h000000000);
    do_req(1'b0, 1'b1, 17'h00005, 36'h0, 4'hf, n);
    check_data(rsp_rdata, 36'hfffffffff);
    do_req(1'b1, 1'b1, 17'h00003, 36'h1, 4'hf, n);
    do_req(1'b0, 1'b1, 17'h00003, 36'h0, 4'hf, n);
    check_data(rsp_rdata, 36'hfffffffff);
  endtask : s_flag

  task automatic s_busy;
    busy_fast <= 1'b1;
    opp_addr  <= 17'h00040;
    opp_sel_n <= 1'b0;
    fork
      do_req(1'b1, 1'b0, 17'h00040, 36'h123456789, 4'hf, n);
      begin
        repeat (8) @(posedge ref_clk);
        #1;
        check_bit(busy_n, 1'b0);
        check_bit(rw_n, 1'b0);
        check_bit(rsp_valid, 1'b0);
        opp_sel_n <= 1'b1;
      end
    join
    check_cyc(n, 8, 14);
    opp_sel_n <= 1'b1;
    do_req(1'b0, 1'b0, 17'h00040, 36'h0, 4'hf, n);
    check_data(rsp_rdata, 36'h123456789);
    // read held off by busy until the release delay has passed
    opp_sel_n <= 1'b0;
    fork
      do_req(1'b0, 1'b0, 17'h00040, 36'h0, 4'hf, n);
      begin
        repeat (6) @(posedge ref_clk);
        #1;
        check_bit(oe_n, 1'b0);
        check_bit(rsp_valid, 1'b0);
        opp_sel_n <= 1'b1;
      end
    join
    check_cyc(n, 9, 13);
    check_data(rsp_rdata, 36'h123456789);
  endtask : s_busy

  // pin rules watched on every falling edge
  always @(negedge ref_clk) if (!rst) begin
    check_bit(busy_fwd_n, busy_n);
    if (!rw_n) begin
      check_bit(oe_n, 1'b1);
      check_bit(dq_oe, 1'b1);
    end
    if (addr !== prev_addr) check_bit(sel_hi_prev & ce_n & flag_space_select_n, 1'b1);
    prev_addr <= addr;
    sel_hi_prev <= ce_n & flag_space_select_n & rw_n;
  end

  // watchdog against a hang
  initial begin
    #20000;
    num_errors++;
    $display("MISMATCH t=%0t watchdog expired", $time);
    summarize();
  end

  // main sequence
  initial begin
    rst = 1'b1;
    {req_valid, req_write, req_flag, busy_fast} = 4'h0;
    opp_sel_n = 1'b1;
    {req_addr, opp_addr, prev_addr} = '0;
    req_wdata = 36'h0;
    req_be = 4'h0;
    sel_hi_prev = 1'b1;
    num_errors = 0;
    check_count = 0;
    repeat (3) @(posedge ref_clk);
    rst <= 1'b0;
    @(negedge ref_clk);
    check_bit(ce_n & flag_space_select_n & rw_n & oe_n & ~dq_oe & req_ready, 1'b1);
    s_array();
    s_flag();
    s_busy();
    summarize();
  end
endmodule : dual_port_ram_write_sem_arbitration_tb_top

`default_nettype wire
